// file: core/igd_pkg.sv
// Shared constants, types and helpers for instruction group dispatch.
// Assumes one core clock and slot 0 of the staging queue as oldest.
package igd_pkg;
    // Slot geometry and register index widths
    localparam int SLOTS     = 4;
    localparam int IREG_W    = 5;
    localparam int FREG_W    = 6;
    localparam int HCNT_W    = 4;
    localparam int BCNT_W    = 4;
    localparam int ISRC_N    = 3;
    localparam int FSRC_N    = 2;
    // Store data operands (integer and float source index)
    localparam int SRC_DATA  = 2;
    localparam int FSRC_DATA = 0;
    // Pipe mask bit positions
    localparam int PIPES     = 6;
    localparam int P_A0      = 0;
    localparam int P_A1      = 1;
    localparam int P_MS      = 2;
    localparam int P_BR      = 3;
    localparam int P_FGA     = 4;
    localparam int P_FGM     = 5;
    // Instruction class flag positions
    localparam int CLS_W     = 7;
    localparam int C_STORE   = 0;
    localparam int C_FSTORE  = 1;
    localparam int C_HVAR    = 2;
    localparam int C_GSRW    = 3;
    localparam int C_ASRW    = 4;
    localparam int C_PIXEL_DISTANCE_OP   = 5;
    localparam int C_FDIV    = 6;
    // Latencies and counts in cycles; ST_GAP counts dispatched groups
    localparam int FP_LAT    = 4;
    localparam int PIXEL_DISTANCE_OP_LAT = 1;
    localparam int HIST_D    = FP_LAT - 1;
    localparam int ST_GAP    = 2;
    localparam logic [HCNT_W-1:0] ASR_BUB  = 4'h7;
    localparam logic [HCNT_W-1:0] HCNT_ONE = 4'h1;
    localparam logic [BCNT_W-1:0] BCNT_ONE = 4'h1;
    // Divide unit busy bits: first part, last part
    localparam int DIV_P1    = 0;
    localparam int DIV_P2    = 1;

    typedef enum logic [2:0] {
        ST_RUN  = 3'h1,
        ST_HELP = 3'h2,
        ST_BUB  = 3'h4
    } igd_mode_t;

    // Single halves alias the doubles built from them
    function automatic logic f_overlap(
        input logic [FREG_W-1:0] a,
        input logic              ad,
        input logic [FREG_W-1:0] b,
        input logic              bd
    );
        if (ad || bd)
            return a[FREG_W-1:1] == b[FREG_W-1:1];
        return a == b;
    endfunction
endpackage

// file: core/igd_busy_trk.sv
// Helper cycles, forced bubbles and blocking pipe reservation.
// Assumes dispatch events are one-cycle pulses on the same clock.
`timescale 1ns/10ps
module igd_busy_trk
    import igd_pkg::*;
#(
    parameter int PW = PIPES
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Dispatch events
    input  wire logic              help_go,
    input  wire logic [HCNT_W-1:0] help_n,
    input  wire logic              asr_go,
    input  wire logic              blk_go,
    input  wire logic [BCNT_W-1:0] blk_cyc,
    input  wire logic [PW-1:0]     blk_pipe,
    // Hold status
    output logic                   hold_o,
    output logic                   helper_o,
    output logic [PW-1:0]          rsv_o
);
    typedef struct packed {
        igd_mode_t         mode;
        logic [HCNT_W-1:0] cnt;
        logic [PW-1:0]     rmask;
        logic [BCNT_W-1:0] rcnt;
    } igd_busy_t;

    igd_busy_t q, d;

    always_comb begin
        d = q;
        case (q.mode)
            ST_RUN: begin
                if (help_go && help_n != '0) begin
                    d.mode = ST_HELP;
                    d.cnt  = help_n;
                end else if (asr_go) begin
                    d.mode = ST_BUB;
                    d.cnt  = ASR_BUB;
                end
            end
            ST_HELP, ST_BUB: begin
                d.cnt = q.cnt - 1'b1;
                if (q.cnt == HCNT_ONE)
                    d.mode = ST_RUN;
            end
            default: d.mode = ST_RUN;
        endcase
        if (q.rcnt != '0)
            d.rcnt = q.rcnt - 1'b1;
        if (blk_go && blk_cyc > BCNT_ONE) begin
            d.rmask = blk_pipe;
            d.rcnt  = blk_cyc - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            q <= '{mode: ST_RUN, cnt: '0, rmask: '0, rcnt: '0};
        else
            q <= d;
    end

    assign hold_o   = q.mode != ST_RUN;
    assign helper_o = q.mode == ST_HELP;
    assign rsv_o    = (q.rcnt != '0) ? q.rmask : '0;
endmodule

// file: core/igd_fp_hist.sv
// Recent float destinations by age, for latency interlocks.
// Assumes writes are the float results dispatched this cycle.
`timescale 1ns/10ps
module igd_fp_hist
    import igd_pkg::*;
#(
    parameter int N = SLOTS
) (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst_b,
    // Dispatched producers
    input  wire logic [N-1:0]                      wr_v,
    input  wire logic [N-1:0][FREG_W-1:0]          wr_dst,
    input  wire logic [N-1:0]                      wr_dbl,
    input  wire logic [N-1:0]                      wr_pd,
    // Waiting consumers
    input  wire logic [N-1:0][FSRC_N-1:0]          rd_v,
    input  wire logic [N-1:0][FSRC_N-1:0][FREG_W-1:0] rd,
    input  wire logic [N-1:0][FSRC_N-1:0]          rd_dbl,
    input  wire logic [N-1:0]                      rd_pd,
    // Per-slot interlock
    output logic [N-1:0]                           haz_o
);
    typedef struct packed {
        logic [HIST_D-1:0][N-1:0]             v;
        logic [HIST_D-1:0][N-1:0][FREG_W-1:0] dst;
        logic [HIST_D-1:0][N-1:0]             dbl;
        logic [HIST_D-1:0][N-1:0]             pd;
    } igd_hist_t;

    igd_hist_t q, d;

    always_comb begin
        d        = q;
        d.v[0]   = wr_v;
        d.dst[0] = wr_dst;
        d.dbl[0] = wr_dbl;
        d.pd[0]  = wr_pd;
        for (int a = 1; a < HIST_D; a++) begin
            d.v[a]   = q.v[a-1];
            d.dst[a] = q.dst[a-1];
            d.dbl[a] = q.dbl[a-1];
            d.pd[a]  = q.pd[a-1];
        end
    end

    // Entry at index a was dispatched a+1 cycles ago
    always_comb begin
        haz_o = '0;
        for (int i = 0; i < N; i++)
            for (int k = 0; k < FSRC_N; k++)
                for (int a = 0; a < HIST_D; a++)
                    for (int e = 0; e < N; e++)
                        if (q.v[a][e] && rd_v[i][k] &&
                            f_overlap(rd[i][k], rd_dbl[i][k],
                                      q.dst[a][e], q.dbl[a][e])) begin
                            if (q.pd[a][e] && rd_pd[i]) begin
                                if (a + 1 < PIXEL_DISTANCE_OP_LAT)
                                    haz_o[i] = 1'b1;
                            end else if (a + 1 < FP_LAT) begin
                                haz_o[i] = 1'b1;
                            end
                        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end
endmodule

// file: core/igd_dispatch.sv
// Dispatch-stage grouping and interlock logic for the staging slots.
// Assumes slot 0 is oldest and all inputs come from the core clock.
`timescale 1ns/10ps
// Function
// - A group holds only conflict-free parallel instructions, settled before dispatch.
// - Nothing younger than a held instruction dispatches that cycle.
// - Hold a source matching the memory pipe execute-stage destination.
// - Cache-stage destination match holds only for late producers like signed byte loads.
// - No check against the memory pipe miss-stage destination.
// - Helpers come from the dispatch stage, counted by opcode or units.
// - An instruction needing helpers is the youngest of its group.
// - A helper cycle dispatches alone and blocks everything else.
// - Two writers of one integer register break the group before the second.
// - Same-group float writers allowed; older write suppressed by age.
// - Condition-code setters group freely with integer branches.
// - No same-group bypass except store data from an older producer.
// - A consumer dispatches no earlier than producer latency after it.
// - Float and media latency is four, bar divide and pixel chains.
// - Dependency checks see single halves aliasing double registers.
// - Two divide busy bits; a new divide waits for part one.
// - Nothing enters the float multiply pipe when a divide changes parts.
// - A float store using a divide result waits for completion.
// - Graphics status writers end their group.
// - Pixel distance to pixel distance latency one, otherwise four.
// - Pixel distance waits for miss-stage stores and stores two groups ahead.
// - Blocking multicycle instructions reserve their pipes until done.
// - On a dependency the whole group stays until it clears.
// - State writes end their group and force seven bubbles.
module igd_dispatch
    import igd_pkg::*;
#(
    parameter int N = SLOTS
) (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               rst_b,
    // Staging slots, slot 0 oldest
    input  wire logic [N-1:0]                       sl_vld,
    input  wire logic [N-1:0][PIPES-1:0]            sl_pipe,
    input  wire logic [N-1:0][CLS_W-1:0]            sl_cls,
    input  wire logic [N-1:0][HCNT_W-1:0]           sl_help_n,
    input  wire logic [N-1:0][BCNT_W-1:0]           sl_blk_cyc,
    input  wire logic [N-1:0]                       sl_idst_v,
    input  wire logic [N-1:0][IREG_W-1:0]           sl_idst,
    input  wire logic [N-1:0][ISRC_N-1:0]           sl_isrc_v,
    input  wire logic [N-1:0][ISRC_N-1:0][IREG_W-1:0] sl_isrc,
    input  wire logic [N-1:0]                       sl_fdst_v,
    input  wire logic [N-1:0][FREG_W-1:0]           sl_fdst,
    input  wire logic [N-1:0]                       sl_fdst_dbl,
    input  wire logic [N-1:0][FSRC_N-1:0]           sl_fsrc_v,
    input  wire logic [N-1:0][FSRC_N-1:0][FREG_W-1:0] sl_fsrc,
    input  wire logic [N-1:0][FSRC_N-1:0]           sl_fsrc_dbl,
    // Pipe status
    input  wire logic                               ms_e_dst_v,
    input  wire logic [IREG_W-1:0]                  ms_e_dst,
    input  wire logic                               ms_c_dst_v,
    input  wire logic [IREG_W-1:0]                  ms_c_dst,
    input  wire logic                               ms_c_late,
    input  wire logic                               st_in_m,
    input  wire logic [HCNT_W-1:0]                  var_help_n,
    input  wire logic                               fdiv_p1_done,
    input  wire logic                               fdiv_p2_done,
    // Dispatch results
    output logic [N-1:0]                            disp_o,
    output logic [N-1:0]                            fp_kill_o,
    output logic                                    helper_o,
    output logic                                    fgm_hold_o,
    output logic [1:0]                              div_busy_o
);
    typedef struct packed {
        logic [ST_GAP-1:0] st_hist;
        logic [1:0]        div_busy;
        logic [1:0][FREG_W-1:0] div_dst;
        logic [1:0]             div_dbl;
    } igd_main_t;

    igd_main_t         s_q, s_d;
    logic [N-1:0]      nh, brk, gm, haz, fp_haz, disp, f_wv;
    logic [N-1:0]      st_v, fgm_v, div_v, pd_v, asr_v;
    logic [PIPES-1:0]  rsv, blk_pipe;
    logic [HCNT_W-1:0] help_n;
    logic [BCNT_W-1:0] blk_cyc;
    logic              hold, any_haz, help_go, asr_go, blk_go, open;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            nh[i]    = sl_help_n[i] != '0 || sl_cls[i][C_HVAR];
            st_v[i]  = sl_cls[i][C_STORE] || sl_cls[i][C_FSTORE];
            fgm_v[i] = sl_pipe[i][P_FGM];
            div_v[i] = sl_cls[i][C_FDIV];
            pd_v[i]  = sl_cls[i][C_PIXEL_DISTANCE_OP];
            asr_v[i] = sl_cls[i][C_ASRW];
        end
    end

    // Group breaks against older members; cc setters and integer
    // branches need no break since the branch reads cc in execute
    always_comb begin
        brk = '0;
        for (int i = 0; i < N; i++) begin
            if (!sl_vld[i])
                brk[i] = 1'b1;
            for (int j = 0; j < i; j++) begin
                if ((sl_pipe[i] & sl_pipe[j]) != '0)
                    brk[i] = 1'b1;
                if (sl_idst_v[i] && sl_idst_v[j] &&
                    sl_idst[i] == sl_idst[j])
                    brk[i] = 1'b1;
                for (int k = 0; k < ISRC_N; k++)
                    if (sl_isrc_v[i][k] && sl_idst_v[j] &&
                        sl_isrc[i][k] == sl_idst[j] &&
                        !(k == SRC_DATA && sl_cls[i][C_STORE]))
                        brk[i] = 1'b1;
                for (int k = 0; k < FSRC_N; k++)
                    if (sl_fsrc_v[i][k] && sl_fdst_v[j] &&
                        f_overlap(sl_fsrc[i][k], sl_fsrc_dbl[i][k],
                                  sl_fdst[j], sl_fdst_dbl[j]) &&
                        !(k == FSRC_DATA && sl_cls[i][C_FSTORE]))
                        brk[i] = 1'b1;
                if (nh[j])
                    brk[i] = 1'b1;
                if (sl_cls[j][C_GSRW])
                    brk[i] = 1'b1;
                if (asr_v[j])
                    brk[i] = 1'b1;
            end
        end
        open = 1'b1;
        for (int i = 0; i < N; i++) begin
            open  = open && !brk[i];
            gm[i] = open;
        end
    end

    // Interlocks against instructions already in the pipes; the
    // miss-stage destination is never compared, its data is ready
    always_comb begin
        haz = '0;
        for (int i = 0; i < N; i++) begin
            for (int k = 0; k < ISRC_N; k++) begin
                if (sl_isrc_v[i][k] && ms_e_dst_v &&
                    sl_isrc[i][k] == ms_e_dst)
                    haz[i] = 1'b1;
                if (sl_isrc_v[i][k] && ms_c_dst_v && ms_c_late &&
                    sl_isrc[i][k] == ms_c_dst)
                    haz[i] = 1'b1;
            end
            // Each part keeps its own dest; a newer divide must not
            // hide the older one still finishing its last part
            for (int k = 0; k < FSRC_N; k++)
                for (int p = 0; p < 2; p++)
                    if (sl_fsrc_v[i][k] && s_q.div_busy[p] &&
                        f_overlap(sl_fsrc[i][k], sl_fsrc_dbl[i][k],
                                  s_q.div_dst[p], s_q.div_dbl[p]))
                        haz[i] = 1'b1;
            if (fp_haz[i])
                haz[i] = 1'b1;
            if (div_v[i] && s_q.div_busy[DIV_P1])
                haz[i] = 1'b1;
            if (fgm_v[i] && fdiv_p1_done)
                haz[i] = 1'b1;
            if (pd_v[i] && (st_in_m || s_q.st_hist[ST_GAP-1]))
                haz[i] = 1'b1;
            if ((sl_pipe[i] & rsv) != '0)
                haz[i] = 1'b1;
        end
    end

    // Whole group waits on any member's hazard, keeping order intact
    assign any_haz = (haz & gm) != '0;
    assign disp    = (hold || any_haz) ? '0 : gm;

    always_comb begin
        help_go  = 1'b0;
        help_n   = '0;
        blk_go   = 1'b0;
        blk_cyc  = '0;
        blk_pipe = '0;
        for (int i = 0; i < N; i++) begin
            if (disp[i] && nh[i]) begin
                help_go = 1'b1;
                help_n  = sl_cls[i][C_HVAR] ? var_help_n
                                            : sl_help_n[i];
            end
            if (disp[i] && sl_blk_cyc[i] > BCNT_ONE) begin
                blk_go   = 1'b1;
                blk_cyc  = sl_blk_cyc[i];
                blk_pipe = sl_pipe[i];
            end
        end
        asr_go = (disp & asr_v) != '0;
    end

    // Older of two same-group float writers loses its register write
    always_comb begin
        fp_kill_o = '0;
        for (int i = 0; i < N; i++)
            for (int j = i + 1; j < N; j++)
                if (disp[i] && disp[j] && sl_fdst_v[i] &&
                    sl_fdst_v[j] &&
                    f_overlap(sl_fdst[i], sl_fdst_dbl[i],
                              sl_fdst[j], sl_fdst_dbl[j]))
                    fp_kill_o[i] = 1'b1;
    end

    // Divide dest tracked by busy bits, not the fixed-latency history
    assign f_wv = disp & sl_fdst_v & ~div_v;

    always_comb begin
        s_d = s_q;
        if (disp != '0)
            s_d.st_hist = {s_q.st_hist[ST_GAP-2:0],
                           (disp & st_v) != '0};
        if (fdiv_p2_done)
            s_d.div_busy[DIV_P2] = 1'b0;
        if (fdiv_p1_done) begin
            s_d.div_busy[DIV_P1] = 1'b0;
            s_d.div_busy[DIV_P2] = 1'b1;
            s_d.div_dst[DIV_P2]  = s_q.div_dst[DIV_P1];
            s_d.div_dbl[DIV_P2]  = s_q.div_dbl[DIV_P1];
        end
        for (int i = 0; i < N; i++)
            if (disp[i] && div_v[i]) begin
                s_d.div_busy[DIV_P1] = 1'b1;
                s_d.div_dst[DIV_P1] = sl_fdst[i];
                s_d.div_dbl[DIV_P1] = sl_fdst_dbl[i];
            end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    igd_fp_hist #(
        .N      (N)
    ) u_hist (
        .clk    (clk),
        .rst_b  (rst_b),
        .wr_v   (f_wv),
        .wr_dst (sl_fdst),
        .wr_dbl (sl_fdst_dbl),
        .wr_pd  (pd_v),
        .rd_v   (sl_fsrc_v),
        .rd     (sl_fsrc),
        .rd_dbl (sl_fsrc_dbl),
        .rd_pd  (pd_v),
        .haz_o  (fp_haz)
    );

    igd_busy_trk #(
        .PW       (PIPES)
    ) u_busy (
        .clk      (clk),
        .rst_b    (rst_b),
        .help_go  (help_go),
        .help_n   (help_n),
        .asr_go   (asr_go),
        .blk_go   (blk_go),
        .blk_cyc  (blk_cyc),
        .blk_pipe (blk_pipe),
        .hold_o   (hold),
        .helper_o (helper_o),
        .rsv_o    (rsv)
    );

    assign disp_o     = disp;
    assign fgm_hold_o = fdiv_p1_done;
    assign div_busy_o = s_q.div_busy;

    // Checks
    logic waw, young_bad, e_hit;

    always_comb begin
        waw       = 1'b0;
        young_bad = 1'b0;
        e_hit     = 1'b0;
        for (int i = 0; i < N; i++)
            for (int j = i + 1; j < N; j++) begin
                if (disp[i] && disp[j] && sl_idst_v[i] &&
                    sl_idst_v[j] && sl_idst[i] == sl_idst[j])
                    waw = 1'b1;
                if (disp[i] && nh[i] && disp[j])
                    young_bad = 1'b1;
            end
        for (int k = 0; k < ISRC_N; k++)
            if (ms_e_dst_v && sl_isrc_v[0][k] &&
                sl_isrc[0][k] == ms_e_dst)
                e_hit = 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_disp_prefix: assert property (
        ((disp_o + 1'b1) & disp_o) == '0)
        else $error("dispatch mask not in program order");
    a_help_alone: assert property (
        helper_o |-> disp_o == '0)
        else $error("dispatch during helper cycle");
    a_help_run: assert property (
        help_go && help_n == 4'h2 && !hold
        |=> helper_o [*2] ##1 !helper_o)
        else $error("helper count not honoured");
    a_help_last: assert property (!young_bad)
        else $error("instruction grouped after helper owner");
    a_ms_e_hold: assert property (e_hit |-> !disp_o[0])
        else $error("execute-stage memory pipe match dispatched");
    a_int_waw: assert property (!waw)
        else $error("two integer writers of one register");
    a_asr_bub: assert property (
        asr_go |=> (disp_o == '0) [*7])
        else $error("dispatch inside state-write bubbles");
    a_div_fgm: assert property (
        fdiv_p1_done |-> (disp_o & fgm_v) == '0)
        else $error("multiply pipe issue on divide slot");
    a_div_busy: assert property (
        s_q.div_busy[DIV_P1] |-> (disp_o & div_v) == '0)
        else $error("divide started while first part busy");
    a_pixel_distance_op_st: assert property (
        st_in_m |-> (disp_o & pd_v) == '0)
        else $error("pixel distance issued beside miss store");

    c_full_grp: cover property (disp_o == '1);
    c_helper: cover property (help_go ##1 helper_o);
    c_div: cover property ((disp_o & div_v) != '0);
    c_bubble: cover property (asr_go);
endmodule

// file: test/igd_fgu_model.sv
// Divide unit model: clears the two divide busy stages by pulses.
// Assumes div_go pulses on the edge where a divide dispatches.
`timescale 1ns/10ps
module igd_fgu_model #(
    parameter int P1_LAT = 5,
    parameter int P2_LAT = 3
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Divide start and part completion
    input  wire logic div_go,
    output logic      p1_done,
    output logic      p2_done
);
    int c1;
    int c2;
    // Part two counts apart so a new divide may overlap it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            c1 <= 0;
            c2 <= 0;
            p1_done <= 1'b0;
            p2_done <= 1'b0;
        end else begin
            c1 <= div_go ? 1 : (c1 == 0 || c1 == P1_LAT) ? 0 : c1 + 1;
            p1_done <= (c1 == P1_LAT);
            c2 <= p1_done ? 1 : (c2 == 0 || c2 == P2_LAT) ? 0 : c2 + 1;
            p2_done <= (c2 == P2_LAT);
        end
    end
endmodule

// file: test/instruction_grouping_dispatch_tb_top.sv
// Bench for the dispatch grouping block with a divide unit model.
// Assumes the bench stands in for the staging queue and pipe status.
`timescale 1ns/10ps
module instruction_grouping_dispatch_tb_top import igd_pkg::*;;
    localparam int N = SLOTS;
    localparam int P1 = 5;
    localparam int P2 = 3;
    logic clk, rst_b, ms_e_dst_v, ms_c_dst_v, ms_c_late, st_in_m;
    logic fdiv_p1_done, fdiv_p2_done, helper_o, fgm_hold_o;
    logic [IREG_W-1:0] ms_e_dst, ms_c_dst;
    logic [HCNT_W-1:0] var_help_n;
    logic [1:0] div_busy_o;
    logic [N-1:0] sl_vld, sl_idst_v, sl_fdst_v, sl_fdst_dbl, disp_o, fp_kill_o;
    logic [N-1:0][PIPES-1:0] sl_pipe;
    logic [N-1:0][CLS_W-1:0] sl_cls;
    logic [N-1:0][HCNT_W-1:0] sl_help_n;
    logic [N-1:0][BCNT_W-1:0] sl_blk_cyc;
    logic [N-1:0][IREG_W-1:0] sl_idst;
    logic [N-1:0][ISRC_N-1:0] sl_isrc_v;
    logic [N-1:0][ISRC_N-1:0][IREG_W-1:0] sl_isrc;
    logic [N-1:0][FREG_W-1:0] sl_fdst;
    logic [N-1:0][FSRC_N-1:0] sl_fsrc_v, sl_fsrc_dbl;
    logic [N-1:0][FSRC_N-1:0][FREG_W-1:0] sl_fsrc;
    int fail_count = 0;
    int n_checks = 0;
    igd_dispatch dut (.clk(clk), .rst_b(rst_b), .sl_vld(sl_vld),
        .sl_pipe(sl_pipe), .sl_cls(sl_cls), .sl_help_n(sl_help_n),
        .sl_blk_cyc(sl_blk_cyc), .sl_idst_v(sl_idst_v), .sl_idst(sl_idst),
        .sl_isrc_v(sl_isrc_v), .sl_isrc(sl_isrc), .sl_fdst_v(sl_fdst_v),
        .sl_fdst(sl_fdst), .sl_fdst_dbl(sl_fdst_dbl), .sl_fsrc_v(sl_fsrc_v),
        .sl_fsrc(sl_fsrc), .sl_fsrc_dbl(sl_fsrc_dbl),
        .ms_e_dst_v(ms_e_dst_v), .ms_e_dst(ms_e_dst),
        .ms_c_dst_v(ms_c_dst_v), .ms_c_dst(ms_c_dst), .ms_c_late(ms_c_late),
        .st_in_m(st_in_m), .var_help_n(var_help_n),
        .fdiv_p1_done(fdiv_p1_done), .fdiv_p2_done(fdiv_p2_done),
        .disp_o(disp_o), .fp_kill_o(fp_kill_o), .helper_o(helper_o),
        .fgm_hold_o(fgm_hold_o), .div_busy_o(div_busy_o));
    igd_fgu_model #(.P1_LAT(P1), .P2_LAT(P2)) fgu (.clk(clk), .rst_b(rst_b),
        .div_go(disp_o[0] & sl_cls[0][C_FDIV]), .p1_done(fdiv_p1_done),
        .p2_done(fdiv_p2_done));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic clr;
        {sl_vld, sl_pipe, sl_cls, sl_help_n, sl_blk_cyc, sl_idst_v, sl_idst,
         sl_isrc_v, sl_isrc, sl_fdst_v, sl_fdst, sl_fdst_dbl, sl_fsrc_v,
         sl_fsrc, sl_fsrc_dbl, ms_e_dst_v, ms_e_dst, ms_c_dst_v, ms_c_dst,
         ms_c_late, st_in_m, var_help_n} = '0;
    endtask
    // One plain a0 instruction, or an fga pixel distance op, left in slot 0 after the producer pops
    task automatic next_plain(input logic [FREG_W-1:0] src, logic pd);
        @(negedge clk);
        clr;
        sl_vld = 4'h1;
        sl_pipe[0] = pd ? 6'h10 : 6'h01;
        sl_cls[0][C_PIXEL_DISTANCE_OP] = pd;
        sl_fsrc_v[0] = {1'b0, pd};
        sl_fsrc[0][0] = src;
        sl_fsrc_dbl[0] = 2'h1;
    endtask
    // Count cycles with nothing dispatched, bounded
    task automatic stall_cnt(output int n);
        n = 0;
        #1;
        while (disp_o !== 4'h1 && n < 40) begin
            if (fdiv_p1_done === 1'b1) chk("fgmhold", fgm_hold_o, 8'h1);
            n++;
            @(negedge clk);
            #1;
        end
    endtask
    task automatic t_fplat;
        int n;
        for (int k = 0; k < 2; k++) begin
            clr;
            sl_vld = 4'h1;
            sl_pipe[0] = 6'h10;
            sl_cls[0][C_PIXEL_DISTANCE_OP] = k[0];
            sl_fdst_v = 4'h1;
            sl_fdst[0] = 6'h05;
            #1 chk("fpprod", disp_o, 8'h1);
            next_plain(6'h04, k[0]);
            if (k == 0) sl_fsrc_v[0] = 2'h1;
            stall_cnt(n);
            chk("fplat", n, k ? PIXEL_DISTANCE_OP_LAT - 1 : FP_LAT - 1);
            st_in_m = k[0];
            #1 chk("pdmiss", disp_o, k ? 8'h0 : 8'h1);
            @(negedge clk);
        end
    endtask
    task automatic t_group;
        clr;
        sl_vld = 4'h3;
        sl_pipe[0] = 6'h01;
        sl_pipe[1] = 6'h01;
        #1 chk("pipe", disp_o, 8'h1);
        sl_pipe[1] = 6'h02;
        sl_idst_v = 4'h3;
        sl_idst[0] = 5'h03;
        sl_idst[1] = 5'h03;
        #1 chk("waw", disp_o, 8'h1);
        sl_idst_v = 4'h1;
        sl_isrc_v[1] = 3'h1;
        sl_isrc[1][0] = 5'h03;
        #1 chk("bypass", disp_o, 8'h1);
        sl_isrc_v[1] = 3'h4;
        sl_isrc[1][2] = 5'h03;
        sl_cls[1] = 7'h01;
        sl_pipe[1] = 6'h04;
        #1 chk("stdata", disp_o, 8'h3);
        @(negedge clk);
        clr;
        sl_vld = 4'h7;
        sl_pipe = {6'h00, 6'h08, 6'h04, 6'h01};
        sl_isrc_v[2] = 3'h1;
        sl_isrc[2][0] = 5'h09;
        ms_e_dst_v = 1'b1;
        ms_e_dst = 5'h09;
        #1 chk("mse", disp_o, 8'h0);
        {ms_e_dst_v, ms_c_dst_v, ms_c_dst} = {1'b0, 1'b1, 5'h09};
        #1 chk("mscearly", disp_o, 8'h7);
        ms_c_late = 1'b1;
        #1 chk("msclate", disp_o, 8'h0);
        {ms_c_dst_v, sl_cls[0]} = {1'b0, 7'h08};
        #1 chk("gsrw", disp_o, 8'h1);
        @(negedge clk);
        clr;
        {sl_vld, sl_pipe[1], sl_pipe[0]} = {4'h3, 6'h20, 6'h10};
        {sl_fdst_v, sl_fdst[1], sl_fdst[0]} = {4'h3, 6'h03, 6'h02};
        {sl_fdst_dbl, sl_blk_cyc[0]} = {4'h1, 4'h2};
        #1 chk("fpkill", fp_kill_o, 8'h1);
        sl_cls[0][C_PIXEL_DISTANCE_OP] = 1'b1;
        #1 chk("pdgap", disp_o, 8'h0);
        sl_cls[0] = '0;
        @(negedge clk);
        #1 chk("blkrsv", disp_o, 8'h0);
    endtask
    task automatic t_helper;
        int n;
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            clr;
            sl_vld = 4'h3;
            sl_pipe[0] = 6'h04;
            sl_pipe[1] = 6'h01;
            if (k == 0) sl_help_n[0] = 4'h2;
            if (k == 1) {sl_cls[0], var_help_n} = {7'h04, 4'h3};
            if (k == 2) sl_cls[0] = 7'h10;
            #1 chk("helpgrp", disp_o, 8'h1);
            next_plain(6'h00, 1'b0);
            stall_cnt(n);
            chk("helpcyc", n, k == 2 ? 7 : k + 2);
            chk("helpdone", helper_o, 8'h0);
        end
    endtask
    task automatic t_div;
        int n;
        @(negedge clk);
        clr;
        sl_vld = 4'h1;
        {sl_pipe[0], sl_cls[0], sl_fdst_v, sl_fdst[0]} =
            {6'h20, 7'h40, 4'h1, 6'h08};
        #1 chk("div1", disp_o, 8'h1);
        @(negedge clk);
        sl_fdst[0] = 6'h10;
        #1 chk("busy1", div_busy_o, 8'h1);
        stall_cnt(n);
        chk("div2wait", n, P1 + 1);
        @(negedge clk);
        clr;
        #1 chk("busy2", div_busy_o, 8'h3);
        {sl_vld, sl_pipe[0], sl_cls[0]} = {4'h1, 6'h04, 7'h02};
        {sl_fsrc_v[0], sl_fsrc[0][0]} = {2'h1, 6'h08};
        stall_cnt(n);
        chk("fstwait", n, P2);
        chk("fstbusy", div_busy_o[DIV_P2], 8'h0);
    endtask
    initial begin
        rst_b = 1'b0;
        clr;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_fplat();
        t_group();
        t_helper();
        t_div();
        close_out();
    end
    // Whole run is well under a hundred cycles
    initial begin
        #20000;
        fail_count++;
        close_out();
    end
endmodule
